// *** fcr_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module fcr_host (
   input  wire logic       clk,
   output var  logic       sclk,
   output var  logic       cs_b,
   output var  logic [3:0] dq_in,
   input  wire logic [3:0] dq_out,
   input  wire logic [3:0] dq_oe
);
   logic [3:0] bus;
   // An undriven lane reads back inverted, so a stale output never passes
   assign bus = ~(dq_out ^ dq_oe);
   initial begin
      sclk = 1'b0;
      cs_b = 1'b1;
      dq_in = 4'h0;
   end
   // Mode 0 frame, 40 clk per serial bit; serial clock idles low between frames
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, input int nw,
                       input int nr, input int ln, output logic [7:0] rd);
      logic [15:0] sh;
      int          n;
      sh = {cmd, wd};
      n = (8 + 8 * nw) / ln;
      rd = 8'h00;
      cs_b <= 1'b0;
      for (int i = 0; i < n + 8 * nr / ln; i++) begin
         // Released lanes toggle so a stale value never looks valid
         if (i < n) dq_in <= 4'(sh[15:12] >> (4 - ln));
         else dq_in <= ~dq_in;
         sh = sh << ln;
         repeat (20) @(posedge clk);
         if (i >= n) rd = (ln == 1) ? {rd[6:0], bus[1]}
                                    : (rd << ln) | {4'h0, bus & 4'((1 << ln) - 1)};
         sclk <= 1'b1;
         repeat (20) @(posedge clk);
         sclk <= 1'b0;
      end
      repeat (20) @(posedge clk);
      cs_b <= 1'b1;
      dq_in <= ~dq_in;
      repeat (12) @(posedge clk);
   endtask
endmodule // fcr_host
`default_nettype wire

// *** fcr_regs.sv ***
package fcr_pkg;
   localparam logic [7:0] CMD_WREN    = 8'h06;
   localparam logic [7:0] CMD_WRDI    = 8'h04;
   localparam logic [7:0] CMD_WR_CFG  = 8'h61;
   localparam logic [7:0] CMD_RD_CFG  = 8'h65;
   localparam logic [7:0] CMD_RD_FLAG = 8'h70;
   localparam logic [7:0] CMD_CLR_FLG = 8'h50;
   localparam logic [7:0] CFG_RESET   = 8'hdf;
   localparam logic [7:0] CFG_WMASK   = 8'hdf;
   localparam int CFG_QUAD  = 7;
   localparam int CFG_DUAL  = 6;
   localparam int CFG_HOLD  = 4;
   localparam int CFG_ACCEL = 3;
   localparam int CFG_IMP_HI = 2;
   localparam logic [2:0] IMP_RSV0 = 3'h0;
   localparam logic [2:0] IMP_RSV1 = 3'h4;
   localparam int FLG_READY = 7;
   localparam int FLG_ESUSP = 6;
   localparam int FLG_ERASE = 5;
   localparam int FLG_PROG  = 4;
   localparam int FLG_VPP   = 3;
   localparam int FLG_PSUSP = 2;
   localparam int FLG_PROT  = 1;
   localparam logic [7:0] FLG_ERR_MASK = 8'h3a;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] LANE_1 = 4'h1;
   localparam logic [3:0] LANE_2 = 4'h2;
   localparam logic [3:0] LANE_4 = 4'h4;
   localparam logic [3:0] OE_EXT  = 4'h2;
   localparam logic [3:0] OE_DUAL = 4'h3;
   localparam logic [3:0] OE_QUAD = 4'hf;
   localparam int PIN_CS = 5;
   localparam int PIN_SCK = 4;
   typedef enum logic [1:0] {ST_CMD, ST_WDATA, ST_RDATA, ST_DONE} fcr_state_t;
endpackage

`timescale 1ns/100ps
`default_nettype none
module fcr_regs
   import fcr_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       sclk,
   input  wire logic       cs_b,
   input  wire logic [3:0] dq_in,
   output var  logic [3:0] dq_out,
   output var  logic [3:0] dq_oe,
   input  wire logic       pe_busy,
   input  wire logic       nv_write_busy,
   input  wire logic       erase_susp,
   input  wire logic       prog_susp,
   input  wire logic       erase_fail,
   input  wire logic       prog_fail,
   input  wire logic       prog_one_attempt,
   input  wire logic       program_accel_high_level,
   input  wire logic       data_mult64,
   input  wire logic       vpp_invalid,
   input  wire logic       prot_sector,
   input  wire logic       prot_otp,
   input  wire logic       pe_start,
   input  wire logic       pe_is_erase,
   output var  logic       pe_refused,
   output var  logic       quad_mode,
   output var  logic       dual_mode,
   output var  logic       hold_reset_en,
   output var  logic       vpp_accel_en,
   output var  logic [2:0] drive_code,
   output var  logic       write_en_latch
);
   logic [5:0] pins_raw;
   logic [5:0] pins_s;
   logic [5:0] pins_rst;
   logic       sck_prev_q;
   logic       cs_prev_q;
   logic       sck_rise;
   logic       sck_fall;
   logic       cs_end;
   logic       cs_s;
   logic [3:0] lanes;
   logic [3:0] oe_pat;
   logic [7:0] sr_q;
   logic [7:0] sr_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_nx;
   logic       byte_done;
   logic [7:0] cmd_q;
   logic [7:0] wdata_q;
   logic       wvalid_q;
   logic       rd_flag_q;
   logic [7:0] tx_q;
   logic [7:0] tx_val;
   logic [3:0] tcnt_q;
   logic [3:0] tcnt_nx;
   logic [7:0] cfg_q;
   logic [7:0] cfg_new;
   logic [7:0] err_q;
   logic [7:0] err_set;
   logic       clr_err;
   logic [7:0] flag_val;
   logic       wel_q;
   fcr_state_t state_q;

   // Select enters inverted so every stage resets to its idle level: no false edge after reset
   assign pins_raw = {!cs_b, sclk, dq_in};
   assign pins_rst = 6'h00;

   for (genvar i = 0; i < 6; i++) begin : g_sync
      fcr_sync u_sync (
         .clk     (clk),
         .rst_b   (rst_b),
         .pin_in  (pins_raw[i]),
         .rst_val (pins_rst[i]),
         .level_q (pins_s[i])
      );
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sck_prev_q <= 1'b0;
         cs_prev_q  <= 1'b1;
      end else begin
         sck_prev_q <= pins_s[PIN_SCK];
         cs_prev_q  <= cs_s;
      end
   end

   assign cs_s     = !pins_s[PIN_CS];
   assign sck_rise = !cs_s && pins_s[PIN_SCK] && !sck_prev_q;
   assign sck_fall = !cs_s && !pins_s[PIN_SCK] && sck_prev_q;
   assign cs_end   = cs_s && !cs_prev_q;

   // Protocol is decoded from the stored register, so it only moves at a write's end
   assign quad_mode = !cfg_q[CFG_QUAD];
   assign dual_mode = !cfg_q[CFG_DUAL] && cfg_q[CFG_QUAD];
   assign hold_reset_en = cfg_q[CFG_HOLD];
   assign vpp_accel_en  = !cfg_q[CFG_ACCEL];
   assign drive_code    = cfg_q[CFG_IMP_HI:0];
   assign write_en_latch = wel_q;

   // Commands and data use the lanes of the active protocol
   always_comb begin
      if (quad_mode) begin
         lanes  = LANE_4;
         oe_pat = OE_QUAD;
         sr_d   = {sr_q[3:0], pins_s[3:0]};
      end else if (dual_mode) begin
         lanes  = LANE_2;
         oe_pat = OE_DUAL;
         sr_d   = {sr_q[5:0], pins_s[1:0]};
      end else begin
         lanes  = LANE_1;
         oe_pat = OE_EXT;
         sr_d   = {sr_q[6:0], pins_s[0]};
      end
   end

   assign cnt_nx    = cnt_q + lanes;
   assign byte_done = sck_rise && (cnt_nx == BYTE_BITS);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sr_q  <= 8'h00;
         cnt_q <= 4'h0;
      end else if (cs_s) begin
         cnt_q <= 4'h0;
      end else if (sck_rise) begin
         sr_q  <= sr_d;
         cnt_q <= byte_done ? 4'h0 : cnt_nx;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q   <= ST_CMD;
         cmd_q     <= 8'h00;
         wdata_q   <= 8'h00;
         wvalid_q  <= 1'b0;
         rd_flag_q <= 1'b0;
      end else if (cs_s) begin
         state_q <= ST_CMD;
         if (cs_end) begin
            cmd_q    <= 8'h00;
            wvalid_q <= 1'b0;
         end
      end else if (byte_done) begin
         unique case (state_q)
            ST_CMD: begin
               cmd_q <= sr_d;
               if (sr_d == CMD_WR_CFG) begin
                  state_q <= ST_WDATA;
               end else if (sr_d == CMD_RD_CFG || sr_d == CMD_RD_FLAG) begin
                  state_q   <= ST_RDATA;
                  rd_flag_q <= (sr_d == CMD_RD_FLAG);
               end else begin
                  state_q <= ST_DONE;
               end
            end
            ST_WDATA: begin
               wdata_q  <= sr_d;
               wvalid_q <= 1'b1;
               state_q  <= ST_DONE;
            end
            ST_RDATA: state_q <= ST_RDATA;
            ST_DONE:  state_q <= ST_DONE;
         endcase
      end
   end

   // Read data restart from a fresh sample each byte so live flags track the engine
   assign tx_val  = (tcnt_q == 4'h0) ? (rd_flag_q ? flag_val : cfg_q) : tx_q;
   assign tcnt_nx = tcnt_q + lanes;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_q   <= 8'h00;
         tcnt_q <= 4'h0;
         dq_out <= 4'h0;
         dq_oe  <= 4'h0;
      end else if (cs_s) begin
         tcnt_q <= 4'h0;
         dq_oe  <= 4'h0;
      end else if (sck_fall && state_q == ST_RDATA) begin
         dq_oe <= oe_pat;
         if (quad_mode) begin
            dq_out <= tx_val[7:4];
            tx_q   <= {tx_val[3:0], 4'h0};
         end else if (dual_mode) begin
            dq_out <= {2'h0, tx_val[7:6]};
            tx_q   <= {tx_val[5:0], 2'h0};
         end else begin
            dq_out <= {2'h0, tx_val[7], 1'b0};
            tx_q   <= {tx_val[6:0], 1'b0};
         end
         tcnt_q <= (tcnt_nx == BYTE_BITS) ? 4'h0 : tcnt_nx;
      end
   end

   // Reserved impedance codes are refused; the old code stays
   always_comb begin
      cfg_new = (wdata_q & CFG_WMASK) | (cfg_q & ~CFG_WMASK);
      if (wdata_q[CFG_IMP_HI:0] == IMP_RSV0 || wdata_q[CFG_IMP_HI:0] == IMP_RSV1) begin
         cfg_new[CFG_IMP_HI:0] = cfg_q[CFG_IMP_HI:0];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_q <= CFG_RESET;
         wel_q <= 1'b0;
      end else if (cs_end) begin
         if (cmd_q == CMD_WREN) begin
            wel_q <= 1'b1;
         end else if (cmd_q == CMD_WRDI) begin
            wel_q <= 1'b0;
         end else if (cmd_q == CMD_WR_CFG && wvalid_q && wel_q) begin
            cfg_q <= cfg_new;
            wel_q <= 1'b0;
         end
      end
   end

   assign clr_err = cs_end && (cmd_q == CMD_CLR_FLG);

   always_comb begin
      err_set = 8'h00;
      err_set[FLG_ERASE] = erase_fail || (pe_refused && pe_is_erase);
      err_set[FLG_PROG]  = prog_fail || (pe_refused && !pe_is_erase)
                           || (prog_one_attempt && program_accel_high_level
                               && data_mult64);
      err_set[FLG_VPP]   = vpp_invalid;
      err_set[FLG_PROT]  = prot_sector || prot_otp;
   end

   // A new error in the clearing cycle survives the clear
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         err_q <= 8'h00;
      end else if (clr_err) begin
         err_q <= err_set & FLG_ERR_MASK;
      end else begin
         err_q <= (err_q | err_set) & FLG_ERR_MASK;
      end
   end

   assign pe_refused = pe_start && (|err_q);

   always_comb begin
      flag_val = err_q;
      flag_val[FLG_READY] = !(pe_busy || nv_write_busy);
      flag_val[FLG_ESUSP] = erase_susp;
      flag_val[FLG_PSUSP] = prog_susp;
   end

   AST_QUAD_PRIO: assert property (@(posedge clk) disable iff (!rst_b)
      !(quad_mode && dual_mode))
      else $error("quad and dual active together");

   AST_RSV_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
      !cfg_q[5] && !flag_val[0])
      else $error("reserved bit not zero");

   AST_READY: assert property (@(posedge clk) disable iff (!rst_b)
      (pe_busy || nv_write_busy) != flag_val[FLG_READY])
      else $error("ready bit does not track busy");

   AST_SUSP: assert property (@(posedge clk) disable iff (!rst_b)
      flag_val[FLG_ESUSP] == erase_susp && flag_val[FLG_PSUSP] == prog_susp)
      else $error("suspend bits wrong");

   AST_ERR_STICKY: assert property (@(posedge clk) disable iff (!rst_b)
      !clr_err |=> ((err_q & $past(err_q)) == $past(err_q)))
      else $error("error flag dropped without clear");

   AST_ERR_CLR: assert property (@(posedge clk) disable iff (!rst_b)
      (clr_err && err_set == 8'h00) |=> (err_q == 8'h00))
      else $error("clear did not clear error flags");

   AST_REFUSE: assert property (@(posedge clk) disable iff (!rst_b)
      (pe_start && (|err_q)) |=> ($past(pe_is_erase) ? err_q[FLG_ERASE] : err_q[FLG_PROG]))
      else $error("program or erase with pending error not refused");

   AST_PROTO_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
      !cs_end |=> $stable(quad_mode) && $stable(dual_mode))
      else $error("protocol changed outside a write completion");

   AST_PROG_ONE: assert property (@(posedge clk) disable iff (!rst_b)
      (prog_one_attempt && program_accel_high_level && data_mult64) |=> err_q[FLG_PROG])
      else $error("program error not flagged");
endmodule // fcr_regs
`default_nettype wire

// *** fcr_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
// Three-stage synchroniser: the level moves only once stages two and three agree
module fcr_sync (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic pin_in,
   input  wire logic rst_val,
   output var  logic level_q
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic seed_q;

   // Reset value is caught after release, never loaded asynchronously from a port
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_q   <= 1'b0;
         s2_q   <= 1'b0;
         s3_q   <= 1'b0;
         seed_q <= 1'b0;
      end else begin
         s1_q   <= pin_in;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         seed_q <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         level_q <= 1'b0;
      end else if (!seed_q) begin
         level_q <= rst_val;
      end else if (s2_q == s3_q) begin
         level_q <= s3_q;
      end
   end
endmodule // fcr_sync
`default_nettype wire

// *** test_flash_config_and_flag_status_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
   $display("ERROR %0t got %h exp %h", $time, (a), (b)); end end
module test_flash_config_and_flag_status_regs;
   import fcr_pkg::*;
   logic       clk, rst_b, sclk, cs_b, busy, nvb, esp, psp, pst, pse;
   logic       refused, quad, dual, hold, accel, wel;
   logic [3:0] dq_in, dq_out, dq_oe;
   logic [7:0] ev, rd;
   logic [2:0] dc;
   int         mismatches = 0;
   int         tests_run = 0;

   fcr_regs dut (.clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .dq_in(dq_in),
      .dq_out(dq_out), .dq_oe(dq_oe), .pe_busy(busy), .nv_write_busy(nvb),
      .erase_susp(esp), .prog_susp(psp), .erase_fail(ev[0]), .prog_fail(ev[1]),
      .vpp_invalid(ev[2]), .prot_sector(ev[3]), .prot_otp(ev[4]),
      .prog_one_attempt(ev[5]), .program_accel_high_level(ev[6]), .data_mult64(ev[7]),
      .pe_start(pst), .pe_is_erase(pse), .pe_refused(refused), .quad_mode(quad),
      .dual_mode(dual), .hold_reset_en(hold), .vpp_accel_en(accel), .drive_code(dc),
      .write_en_latch(wel));
   fcr_host host (.clk(clk), .sclk(sclk), .cs_b(cs_b), .dq_in(dq_in), .dq_out(dq_out),
      .dq_oe(dq_oe));

   task automatic rd_reg(input logic [7:0] c, input int ln);
      host.xfer(c, 8'h00, 0, 1, ln, rd);
   endtask
   task automatic wr_cfg(input logic [7:0] d, input int ln);
      host.xfer(CMD_WREN, 8'h00, 0, 0, ln, rd);
      host.xfer(CMD_WR_CFG, d, 1, 0, ln, rd);
   endtask
   task automatic clr_flags();
      host.xfer(CMD_CLR_FLG, 8'h00, 0, 0, 1, rd);
      rd_reg(CMD_RD_FLAG, 1);
      `CHK(rd, 8'h80)
   endtask
   task automatic t_reset();
      rd_reg(CMD_RD_CFG, 1);
      `CHK(rd, 8'hdf)
      `CHK({quad, dual, hold, accel, dc}, 7'h17)
      rd_reg(CMD_RD_FLAG, 1);
      `CHK(rd, 8'h80)
   endtask
   task automatic t_refused();
      host.xfer(CMD_WR_CFG, 8'h3f, 1, 0, 1, rd);
      host.xfer(CMD_WREN, 8'h00, 0, 0, 1, rd);
      `CHK(wel, 1'b1)
      rd_reg(CMD_RD_FLAG, 1);
      `CHK(rd, 8'h80)
      host.xfer(CMD_WRDI, 8'h00, 0, 0, 1, rd);
      host.xfer(CMD_WR_CFG, 8'h3f, 1, 0, 1, rd);
      rd_reg(CMD_RD_CFG, 1);
      `CHK(rd, 8'hdf)
   endtask
   task automatic t_imp();
      logic [2:0] code;
      code = 3'h7;
      // Reserved codes sit between live ones, so a kept old code is visible
      for (int c = 0; c < 8; c++) begin
         wr_cfg(8'hf8 | 8'(c), 1);
         if (c != 0 && c != 4) code = 3'(c);
         rd_reg(CMD_RD_CFG, 1);
         `CHK(rd, {5'h1b, code})
         `CHK(dc, code)
      end
      wr_cfg(8'hc7, 1);
      `CHK({hold, accel, wel}, 3'b010)
   endtask
   task automatic t_proto();
      host.xfer(CMD_WREN, 8'h00, 0, 0, 1, rd);
      `CHK(dual, 1'b0)
      host.xfer(CMD_WR_CFG, 8'h9f, 1, 0, 1, rd);
      `CHK({quad, dual}, 2'b01)
      rd_reg(CMD_RD_CFG, 2);
      `CHK(rd, 8'h9f)
      wr_cfg(8'h1f, 2);
      `CHK({quad, dual}, 2'b10)
      rd_reg(CMD_RD_CFG, 4);
      `CHK(rd, 8'h1f)
      wr_cfg(8'h5f, 4);
      `CHK({quad, dual}, 2'b10)
      wr_cfg(8'hdf, 4);
      `CHK({quad, dual, dq_oe}, 6'h00)
   endtask
   task automatic t_status();
      busy <= 1'b1;
      rd_reg(CMD_RD_FLAG, 1);
      `CHK(rd, 8'h00)
      busy <= 1'b0;
      nvb <= 1'b1;
      rd_reg(CMD_RD_FLAG, 1);
      `CHK(rd, 8'h00)
      nvb <= 1'b0;
      esp <= 1'b1;
      psp <= 1'b1;
      rd_reg(CMD_RD_FLAG, 1);
      `CHK(rd, 8'hc4)
      esp <= 1'b0;
      psp <= 1'b0;
      rd_reg(CMD_RD_FLAG, 1);
      `CHK(rd, 8'h80)
   endtask
   task automatic t_errors();
      logic [7:0] pat [7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'he0, 8'h60};
      logic [7:0] exp [7] = '{8'h20, 8'h10, 8'h08, 8'h02, 8'h02, 8'h10, 8'h00};
      for (int i = 0; i < 7; i++) begin
         ev <= pat[i];
         @(posedge clk);
         ev <= 8'h00;
         rd_reg(CMD_RD_FLAG, 1);
         `CHK(rd, 8'h80 | exp[i])
         rd_reg(CMD_RD_FLAG, 1);
         `CHK(rd, 8'h80 | exp[i])
         clr_flags();
      end
   endtask
   task automatic t_pe_refuse();
      pst <= 1'b1;
      pse <= 1'b1;
      @(posedge clk);
      #1 `CHK(refused, 1'b0)
      @(posedge clk);
      pst <= 1'b0;
      ev <= 8'h08;
      @(posedge clk);
      ev <= 8'h00;
      pst <= 1'b1;
      pse <= 1'b0;
      @(posedge clk);
      #1 `CHK(refused, 1'b1)
      @(posedge clk);
      pst <= 1'b0;
      rd_reg(CMD_RD_FLAG, 1);
      `CHK(rd, 8'h92)
      clr_flags();
   endtask

   task automatic end_of_test();
      $display("tests_run %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // About 43k cycles of frames expected; a hang stops at 90k, about twice that
   initial begin
      repeat (90000) @(posedge clk);
      mismatches++;
      end_of_test();
   end
   initial begin
      rst_b = 1'b0;
      {busy, nvb, esp, psp, pst, pse} = 6'h00;
      ev = 8'h00;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (12) @(posedge clk);
      t_reset();
      t_refused();
      t_imp();
      t_proto();
      t_status();
      t_errors();
      t_pe_refuse();
      end_of_test();
   end
endmodule // test_flash_config_and_flag_status_regs
`default_nettype wire
